// *** pmc_chk_sva.sv ***
/*
 * Port assertions for the mode controller, bound below.
 * Assumes one clock, active-high async reset.
 */
`timescale 1ns/1ps
module pmc_chk_sva
    import pmc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [9:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        en_i,
    input wire logic        addr_low_strap_i,
    input wire logic        led_blink_strap_i,
    input wire logic        temp_hot_i,
    input wire logic        det_start_o,
    input wire logic        meas_abort_o,
    input wire logic        port_power_o,
    input wire logic [6:0]  dev_addr_o,
    input wire logic        int_n_o,
    input wire logic        int_oe_n_o,
    input wire logic        led_oe_n_o
);
    // ==========
    // enable low run length
    localparam int unsigned LIM = EN_RST_CYC + 2;
    logic [11:0] en_cnt_r;
    logic        wr_ok;
    logic [7:0]  idx;
    assign wr_ok = avs_write_i && !avs_waitrequest_o;
    assign idx = avs_address_i[9:2];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i || en_i) en_cnt_r <= 12'h0;
        else if (en_cnt_r < 12'(LIM)) en_cnt_r <= en_cnt_r + 12'h1;
    end
    // ==========
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_wait_one: assert property ($rose(avs_read_i || avs_write_i)
        |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bad wait state");
    a_rd_upper: assert property (avs_read_i && !avs_waitrequest_o
        |-> avs_readdata_o[31:8] == 24'h0) else $error("read data upper bits set");
    a_en_reset: assert property (en_cnt_r == 12'(LIM) |-> !port_power_o && !det_start_o)
        else $error("enable reset left port active");
    a_soft_off: assert property (wr_ok && idx == REG_RST && avs_writedata_i[B_SOFT_RST]
        |=> !port_power_o) else $error("soft reset left power on");
    a_hot_off: assert property (temp_hot_i ##1 temp_hot_i |=> !port_power_o)
        else $error("power on while hot");
    a_clear_off: assert property (wr_ok && idx == REG_RST && avs_writedata_i[B_PORT_CLR]
        |=> !port_power_o) else $error("port clear left power on");
    a_led_steady: assert property ($past(!led_blink_strap_i) && port_power_o
        |-> !led_oe_n_o) else $error("led not steady");
    a_clr_int: assert property (wr_ok && idx == REG_RST && avs_writedata_i[B_PORT_CLR]
        |=> int_oe_n_o && !int_n_o) else $error("port clear left interrupt");
    a_addr_low: assert property (dev_addr_o == {DEV_ADDR_HI, addr_low_strap_i})
        else $error("device address wrong");
    a_off_cmd: assert property (wr_ok && idx == REG_PWR && avs_writedata_i[B_POWER_OFF_CMD]
        |=> !port_power_o) else $error("power off command ignored");
    a_shut_off: assert property (wr_ok && idx == REG_MODE
        && avs_writedata_i[1:0] == MODE_SHUT |=> !port_power_o) else $error("shutdown kept power");
    c_power: cover property (port_power_o);
    c_abort: cover property (meas_abort_o);
    c_en_rst: cover property (en_cnt_r == 12'(LIM));
endmodule : pmc_chk_sva

bind pmc_port_mode_control pmc_chk_sva pmc_chk_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .en_i(en_i), .addr_low_strap_i(addr_low_strap_i),
    .led_blink_strap_i(led_blink_strap_i), .temp_hot_i(temp_hot_i), .det_start_o(det_start_o),
    .meas_abort_o(meas_abort_o), .port_power_o(port_power_o), .dev_addr_o(dev_addr_o),
    .int_n_o(int_n_o), .int_oe_n_o(int_oe_n_o), .led_oe_n_o(led_oe_n_o));

// *** pmc_meas_model.sv ***
/*
 * Measurement model: answers each start after lat_i cycles.
 * Assumes one-cycle start and abort pulses.
 */
`timescale 1ns/1ps
module pmc_meas_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       det_start_i,
    input  wire logic       cls_start_i,
    input  wire logic       abort_i,
    input  wire logic       det_ok_i,
    input  wire logic [7:0] lat_i,
    output logic            det_done_o,
    output logic            det_valid_o,
    output logic            cls_done_o,
    output logic            cls_valid_o
);
    logic [7:0] dcnt_r;
    logic [7:0] ccnt_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dcnt_r <= 8'h0;
            ccnt_r <= 8'h0;
            det_done_o <= 1'b0;
            cls_done_o <= 1'b0;
            det_valid_o <= 1'b0;
            cls_valid_o <= 1'b0;
        end else begin
            det_done_o <= dcnt_r == 8'h1;
            cls_done_o <= ccnt_r == 8'h1;
            // result only beside done, toggling otherwise
            det_valid_o <= (dcnt_r == 8'h1) ? det_ok_i : ~det_valid_o;
            cls_valid_o <= (ccnt_r == 8'h1) ? 1'b1 : ~cls_valid_o;
            if (abort_i) begin
                dcnt_r <= 8'h0;
                ccnt_r <= 8'h0;
            end else begin
                dcnt_r <= det_start_i ? lat_i : (dcnt_r != 8'h0 ? dcnt_r - 8'h1 : 8'h0);
                ccnt_r <= cls_start_i ? lat_i : (ccnt_r != 8'h0 ? ccnt_r - 8'h1 : 8'h0);
            end
        end
    end
endmodule : pmc_meas_model

// *** pmc_pkg.sv ***
/*
 * Constants of the port mode controller: registers, fields, timing.
 * Assumes a 50 MHz clock.
 */
package pmc_pkg;
    // ==================================================================
    // clock and timing
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned EN_RST_US     = 40;
    localparam int unsigned EN_RST_CYC    = (EN_RST_US * (CLK_HZ / 1_000_000));
    localparam int unsigned BACKOFF_MS    = 2200;
    localparam int unsigned BACKOFF_CYC   = BACKOFF_MS * (CLK_HZ / 1000);
    localparam int unsigned PWM_HZ        = 25_000;
    localparam int unsigned PWM_PERIOD    = CLK_HZ / PWM_HZ;
    localparam int unsigned PWM_DUTY_DIV  = 16;
    localparam int unsigned PWM_ON        = PWM_PERIOD / PWM_DUTY_DIV;

    // ==================================================================
    // register indices
    localparam logic [7:0] REG_EVENT  = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_MODE   = 8'h12;
    localparam logic [7:0] REG_REQ    = 8'h14;
    localparam logic [7:0] REG_CAD    = 8'h15;
    localparam logic [7:0] REG_PWR    = 8'h19;
    localparam logic [7:0] REG_RST    = 8'h1A;
    localparam logic [7:0] REG_DETCFG = 8'h23;

    // ==================================================================
    // field positions
    localparam int B_DET_REQ  = 0;
    localparam int B_CLS_REQ  = 4;
    localparam int B_CAD_EN   = 0;
    localparam int B_POWER_ON_CMD   = 0;
    localparam int B_POWER_OFF_CMD  = 4;
    localparam int B_PORT_CLR = 0;
    localparam int B_SOFT_RST = 4;
    localparam int B_BYPASS   = 4;
    localparam int B_HICAP    = 5;
    localparam int B_EV_DET   = 0;
    localparam int B_EV_CLS   = 4;
    localparam int B_EV_FLT   = 7;

    // ==================================================================
    // mode codes and reset values
    localparam logic [1:0] MODE_SHUT = 2'h0;
    localparam logic [1:0] MODE_MAN  = 2'h1;
    localparam logic [1:0] MODE_SEMI = 2'h2;
    localparam logic [1:0] MODE_AUTO = 2'h3;
    localparam logic [1:0] MODE_RST  = MODE_AUTO;
    // upper serial address bits: arbitrary value
    localparam logic [5:0] DEV_ADDR_HI = 6'h15;
endpackage : pmc_pkg

// *** pmc_port_mode_control.sv ***
/*
 * Mode and reset control for one port, Avalon-MM slave with one wait state.
 * Assumes synchronous inputs and a measurement block that answers starts.
 */
// Function
// - enable low 40 us resets device; straps latch on release.
// - soft reset bit resets all registers, clears itself.
// - thermal shutdown at 150 C, full reset until below 130 C.
// - cadence and high-cap straps used only as latched at reset end.
// - port clear turns off power, clears events, status and both request bits.
// - failed detection with cadence waits 2 to 2.4 s before retry.
// - cadence active from latched strap or cadence enable bit.
// - led blink strap high drives led from PWM, low disables PWM.
// - interrupt pin pulled low while an interrupt is pending.
// - address strap forms low bit of serial address.
// - ac disconnect strap low selects DC sensing, latched at reset end.
// - high-cap strap latched at reset end into high-cap enable.
// - switching among auto, semi, manual keeps port state.
// - shutdown stops port at once; idle until another mode.
// - auto mode after reset; writing 11 selects auto.
// - auto mode detects, classifies, powers valid device; else repeats.
// - entering auto sets both request bits; cleared bit skips phase.
// - auto with detection off powers only when bypass bit set.
// - writing 10 selects semi; repeats requests, never powers itself.
// - semi power-on command aborts detect or classify, powers port.
// - semi request bits default 0; software sets them to run.
// - power-off command clears requests, reset sets both; faults do not clear them.
// - writing 01 selects manual mode under software control.
// - manual requests are one-shot, cleared when the cycle ends.
// - writing 00 selects shutdown: power off, events and status cleared.
// - in shutdown requests and power-on are ignored; bus still works.
`timescale 1ns/1ps
module pmc_port_mode_control
    import pmc_pkg::*;
#(
    parameter int unsigned BACKOFF_CYCLES = BACKOFF_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [9:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        en_i,
    input  wire logic        cadence_strap_i,
    input  wire logic        ac_disconnect_strap_i,
    input  wire logic        high_cap_strap_i,
    input  wire logic        led_blink_strap_i,
    input  wire logic        addr_low_strap_i,
    input  wire logic        temp_hot_i,
    input  wire logic        temp_cool_i,
    input  wire logic        det_done_i,
    input  wire logic        det_valid_i,
    input  wire logic        cls_done_i,
    input  wire logic        cls_valid_i,
    input  wire logic        fault_i,
    output logic             det_start_o,
    output logic             cls_start_o,
    output logic             meas_abort_o,
    output logic             port_power_o,
    output logic             ac_sense_o,
    output logic             high_cap_en_o,
    output logic             cadence_active_o,
    output logic [6:0]       dev_addr_o,
    output logic             int_n_o,
    output logic             int_oe_n_o,
    output logic             led_n_o,
    output logic             led_oe_n_o
);
    // ==================================================================
    // state
    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_DETECT, SEQ_CLASS, SEQ_BACKOFF, SEQ_POWERED
    } pmc_seq_t;

    typedef struct packed {
        logic        ack;
        logic [7:0]  rdata;
        logic [1:0]  mode;
        logic        det_req;
        logic        cls_req;
        logic        cad_bit;
        logic        bypass;
        logic        hicap;
        logic        ev_det, ev_cls, ev_flt;
        logic        det_ok, cls_ok;
        pmc_seq_t    seq;
        logic [26:0] bo_cnt;
        logic [11:0] en_cnt;
        logic        en_hold;
        logic        therm;
        logic        latched;
        logic        cad_strap;
        logic        ac_sense;
        logic        det_start, cls_start, abort;
        logic [10:0] pwm_cnt;
        logic        led_on;
        logic        int_on;
    } pmc_state_t;

    localparam pmc_state_t ST_RST = '{
        mode: MODE_RST, det_req: 1'b1, cls_req: 1'b1, seq: SEQ_IDLE,
        default: '0
    };

    pmc_state_t st_r, st_nxt, keep;
    logic [7:0] idx, wd;
    logic       wr, pon, poff, pclr, srst, rc;
    logic [1:0] m;

    // ==================================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        keep   = st_r;
        idx    = avs_address_i[9:2];
        wd     = avs_writedata_i[7:0];
        st_nxt.det_start = 1'b0;
        st_nxt.cls_start = 1'b0;
        st_nxt.abort     = 1'b0;

        // bus handshake: one wait state, write lands on the ack edge
        st_nxt.ack = (avs_read_i | avs_write_i) & ~st_r.ack;
        wr = avs_write_i & st_r.ack;
        if (avs_read_i && !st_r.ack) begin
            case (idx)
                REG_EVENT:  st_nxt.rdata = {st_r.ev_flt, 2'h0, st_r.ev_cls,
                                            3'h0, st_r.ev_det};
                REG_STATUS: st_nxt.rdata = {1'b0, st_r.latched, st_r.therm,
                                            st_r.cad_strap | st_r.cad_bit,
                                            st_r.ac_sense,
                                            st_r.seq == SEQ_POWERED,
                                            st_r.cls_ok, st_r.det_ok};
                REG_MODE:   st_nxt.rdata = {6'h00, st_r.mode};
                REG_REQ:    st_nxt.rdata = {3'h0, st_r.cls_req, 3'h0,
                                            st_r.det_req};
                REG_CAD:    st_nxt.rdata = {7'h00, st_r.cad_bit};
                REG_DETCFG: st_nxt.rdata = {2'h0, st_r.hicap, st_r.bypass,
                                            4'h0};
                default:    st_nxt.rdata = 8'h00;
            endcase
        end

        // enable pin held low and thermal trip
        if (en_i) begin
            st_nxt.en_cnt  = '0;
            st_nxt.en_hold = 1'b0;
        end else if (st_r.en_cnt != 12'(EN_RST_CYC - 1)) begin
            st_nxt.en_cnt = st_r.en_cnt + 12'h001;
        end else begin
            st_nxt.en_hold = 1'b1;
        end
        if (temp_hot_i) begin
            st_nxt.therm = 1'b1;
        end else if (temp_cool_i) begin
            st_nxt.therm = 1'b0;
        end
        rc = st_r.en_hold | st_r.therm;

        // command decode
        pon  = wr && idx == REG_PWR && wd[B_POWER_ON_CMD];
        poff = wr && idx == REG_PWR && wd[B_POWER_OFF_CMD];
        pclr = wr && idx == REG_RST && wd[B_PORT_CLR];
        srst = wr && idx == REG_RST && wd[B_SOFT_RST];

        // register writes
        if (wr && idx == REG_EVENT) begin
            st_nxt.ev_det = st_r.ev_det & ~wd[B_EV_DET];
            st_nxt.ev_cls = st_r.ev_cls & ~wd[B_EV_CLS];
            st_nxt.ev_flt = st_r.ev_flt & ~wd[B_EV_FLT];
        end
        if (wr && idx == REG_CAD) begin
            st_nxt.cad_bit = wd[B_CAD_EN];
        end
        if (wr && idx == REG_DETCFG) begin
            st_nxt.bypass = wd[B_BYPASS];
            st_nxt.hicap  = wd[B_HICAP];
        end
        if (wr && idx == REG_REQ && st_r.mode != MODE_SHUT) begin
            st_nxt.det_req = wd[B_DET_REQ];
            st_nxt.cls_req = wd[B_CLS_REQ];
        end
        if (wr && idx == REG_MODE && wd[1:0] != st_r.mode) begin
            st_nxt.mode = wd[1:0];
            case (wd[1:0])
                MODE_AUTO: begin
                    st_nxt.det_req = 1'b1;
                    st_nxt.cls_req = 1'b1;
                end
                MODE_SHUT: begin
                    st_nxt.ev_det = 1'b0;
                    st_nxt.ev_cls = 1'b0;
                    st_nxt.ev_flt = 1'b0;
                    st_nxt.det_ok = 1'b0;
                    st_nxt.cls_ok = 1'b0;
                end
                default: begin
                    st_nxt.det_req = 1'b0;
                    st_nxt.cls_req = 1'b0;
                end
            endcase
        end
        if (poff) begin
            st_nxt.det_req = 1'b0;
            st_nxt.cls_req = 1'b0;
        end
        m = st_nxt.mode;
        pon = pon && (m == MODE_SEMI || m == MODE_MAN);

        // port sequencer; switches among auto, semi and manual leave it running
        case (st_r.seq)
            SEQ_IDLE: begin
                if (pon) begin
                    st_nxt.seq = SEQ_POWERED;
                end else if (m == MODE_SHUT) begin
                    st_nxt.seq = SEQ_IDLE;
                end else if (st_nxt.det_req) begin
                    st_nxt.seq       = SEQ_DETECT;
                    st_nxt.det_start = 1'b1;
                end else if (st_nxt.cls_req && (m != MODE_AUTO || st_nxt.bypass)) begin
                    st_nxt.seq       = SEQ_CLASS;
                    st_nxt.cls_start = 1'b1;
                end else if (m == MODE_AUTO && st_nxt.bypass) begin
                    st_nxt.seq = SEQ_POWERED;
                end
            end
            SEQ_DETECT: begin
                if (pon) begin
                    st_nxt.seq   = SEQ_POWERED;
                    st_nxt.abort = 1'b1;
                end else if (det_done_i) begin
                    st_nxt.ev_det = 1'b1;
                    st_nxt.det_ok = det_valid_i;
                    if (m == MODE_MAN) begin
                        st_nxt.det_req = 1'b0;
                    end
                    if (!det_valid_i) begin
                        st_nxt.seq = (st_r.cad_strap | st_nxt.cad_bit)
                                   ? SEQ_BACKOFF : SEQ_IDLE;
                    end else if (st_nxt.cls_req) begin
                        st_nxt.seq       = SEQ_CLASS;
                        st_nxt.cls_start = 1'b1;
                    end else if (m == MODE_AUTO) begin
                        st_nxt.seq = SEQ_POWERED;
                    end else begin
                        st_nxt.seq = SEQ_IDLE;
                    end
                end
            end
            SEQ_CLASS: begin
                if (pon) begin
                    st_nxt.seq   = SEQ_POWERED;
                    st_nxt.abort = 1'b1;
                end else if (cls_done_i) begin
                    st_nxt.ev_cls = 1'b1;
                    st_nxt.cls_ok = cls_valid_i;
                    if (m == MODE_MAN) begin
                        st_nxt.cls_req = 1'b0;
                    end
                    st_nxt.seq = (m == MODE_AUTO && cls_valid_i)
                               ? SEQ_POWERED : SEQ_IDLE;
                end
            end
            SEQ_BACKOFF: begin
                if (pon) begin
                    st_nxt.seq    = SEQ_POWERED;
                    st_nxt.bo_cnt = '0;
                end else if (st_r.bo_cnt == 27'(BACKOFF_CYCLES - 1)) begin
                    st_nxt.seq    = SEQ_IDLE;
                    st_nxt.bo_cnt = '0;
                end else begin
                    st_nxt.bo_cnt = st_r.bo_cnt + 27'h0000001;
                end
            end
            SEQ_POWERED: begin
                if (fault_i) begin
                    st_nxt.seq    = SEQ_IDLE;
                    st_nxt.ev_flt = 1'b1;
                end else if (poff) begin
                    st_nxt.seq = SEQ_IDLE;
                end
            end
            default: st_nxt.seq = SEQ_IDLE;
        endcase

        // shutdown and port clear override the sequencer
        if (m == MODE_SHUT || pclr) begin
            if (st_r.seq == SEQ_DETECT || st_r.seq == SEQ_CLASS) begin
                st_nxt.abort = 1'b1;
            end
            st_nxt.seq       = SEQ_IDLE;
            st_nxt.bo_cnt    = '0;
            st_nxt.det_start = 1'b0;
            st_nxt.cls_start = 1'b0;
        end
        if (pclr) begin
            st_nxt.ev_det  = 1'b0;
            st_nxt.ev_cls  = 1'b0;
            st_nxt.ev_flt  = 1'b0;
            st_nxt.det_ok  = 1'b0;
            st_nxt.cls_ok  = 1'b0;
            st_nxt.det_req = 1'b0;
            st_nxt.cls_req = 1'b0;
        end

        // LED and interrupt pins
        st_nxt.pwm_cnt = (st_r.pwm_cnt == 11'(PWM_PERIOD - 1))
                       ? 11'h000 : st_r.pwm_cnt + 11'h001;
        st_nxt.led_on  = (st_nxt.seq == SEQ_POWERED) &&
                         (!led_blink_strap_i ||
                          st_r.pwm_cnt < 11'(PWM_ON));
        st_nxt.int_on  = st_nxt.ev_det | st_nxt.ev_cls | st_nxt.ev_flt;

        // device reset; straps latch on release
        if (rc || srst) begin
            keep   = st_nxt;
            st_nxt = ST_RST;
            st_nxt.en_cnt  = keep.en_cnt;
            st_nxt.en_hold = keep.en_hold;
            st_nxt.therm   = keep.therm;
            st_nxt.pwm_cnt = keep.pwm_cnt;
            st_nxt.ack     = keep.ack;
            st_nxt.rdata   = keep.rdata;
            st_nxt.abort   = (st_r.seq == SEQ_DETECT || st_r.seq == SEQ_CLASS);
        end else if (!st_r.latched) begin
            st_nxt.latched   = 1'b1;
            st_nxt.cad_strap = cadence_strap_i;
            st_nxt.ac_sense  = ac_disconnect_strap_i;
            st_nxt.hicap     = high_cap_strap_i;
            st_nxt.det_start = 1'b0;
            st_nxt.cls_start = 1'b0;
            st_nxt.seq       = SEQ_IDLE;
        end
    end

    // ==================================================================
    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==================================================================
    // outputs
    assign avs_readdata_o    = {24'h000000, st_r.rdata};
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_r.ack;
    assign det_start_o       = st_r.det_start;
    assign cls_start_o       = st_r.cls_start;
    assign meas_abort_o      = st_r.abort;
    assign port_power_o      = st_r.seq == SEQ_POWERED;
    assign ac_sense_o        = st_r.ac_sense;
    assign high_cap_en_o     = st_r.hicap;
    assign cadence_active_o  = st_r.cad_strap | st_r.cad_bit;
    assign dev_addr_o        = {DEV_ADDR_HI, addr_low_strap_i};
    assign int_n_o           = 1'b0;
    assign int_oe_n_o        = ~st_r.int_on;
    assign led_n_o           = 1'b0;
    assign led_oe_n_o        = ~st_r.led_on;
endmodule : pmc_port_mode_control

// *** testbench.sv ***
/*
 * Self-checking bench for pmc_port_mode_control.
 * Assumes the measurement model and checker.
 */
`timescale 1ns/1ps
module testbench;
    import pmc_pkg::*;
    localparam int BO = 20;
    logic        clk_i = 1'b0;
    logic        rst_i, en_i, cad_s, ac_s, hc_s, led_s, ad_s, hot, cool, fault, det_ok;
    logic        rd, wr, wreq, det_st, cls_st, abrt, pwr, acs, hce, cada;
    logic        int_n, int_oe_n, led_n, led_oe_n, dd, dv, cd, cv;
    logic [9:0]  addr;
    logic [31:0] wdata, rdata;
    logic [6:0]  dev_addr;
    logic [7:0]  lat;
    logic [31:0] exp_q[$];
    int          bad_count, num_checks, cyc, gap;
    int          seed = 32'h2F5F;

    always #10 clk_i = ~clk_i;

    pmc_port_mode_control #(.BACKOFF_CYCLES(BO)) pmc_port_mode_control_inst (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .en_i(en_i), .cadence_strap_i(cad_s),
        .ac_disconnect_strap_i(ac_s), .high_cap_strap_i(hc_s), .led_blink_strap_i(led_s),
        .addr_low_strap_i(ad_s), .temp_hot_i(hot), .temp_cool_i(cool), .det_done_i(dd),
        .det_valid_i(dv), .cls_done_i(cd), .cls_valid_i(cv), .fault_i(fault),
        .det_start_o(det_st), .cls_start_o(cls_st), .meas_abort_o(abrt), .port_power_o(pwr),
        .ac_sense_o(acs), .high_cap_en_o(hce), .cadence_active_o(cada), .dev_addr_o(dev_addr),
        .int_n_o(int_n), .int_oe_n_o(int_oe_n), .led_n_o(led_n), .led_oe_n_o(led_oe_n));
    pmc_meas_model pmc_meas_model_inst (.clk_i(clk_i), .rst_i(rst_i), .det_start_i(det_st),
        .cls_start_i(cls_st), .abort_i(abrt), .det_ok_i(det_ok), .lat_i(lat),
        .det_done_o(dd), .det_valid_o(dv), .cls_done_o(cd), .cls_valid_o(cv));

    // ==========
    // shared tasks
    task automatic chk(input logic [31:0] got, want);
        num_checks++;
        if (got !== want) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        addr <= {idx, 2'b00};
        rd <= !w;
        wr <= w;
        wdata <= d;
        do @(posedge clk_i); while (wreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        #1;
    endtask : bus
    task rd_exp(input logic [7:0] idx, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, idx, 32'h0);
    endtask : rd_exp
    task wpwr(input logic v);
        while (pwr !== v) @(posedge clk_i);
        #1 chk(pwr, v);
    endtask : wpwr
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // read results compared in order of request
    always @(posedge clk_i) if (rd && wreq === 1'b0) chk(rdata, exp_q.pop_front());
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end

    // ==========
    // main sequence
    initial begin
        {rst_i, en_i, cad_s, ac_s, hc_s, led_s, hot, cool, fault} = 9'h190;
        {rd, wr, addr, wdata, det_ok} = 45'h1;
        ad_s = 1'($random(seed));
        lat = 8'h2 + 8'($random(seed) & 7);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_exp(REG_MODE, 32'h3);
        rd_exp(REG_REQ, 32'h11);
        rd_exp(REG_CAD, 32'h0);
        rd_exp(8'h30, 32'h0);
        chk({acs, hce, cada}, 3'h2);
        chk(dev_addr, {DEV_ADDR_HI, ad_s});
        wpwr(1'b1);
        chk({int_oe_n, led_oe_n}, 2'h0);
        $display("test 1 done");
        cad_s <= 1'b1;
        hc_s <= 1'b0;
        bus(1'b1, REG_CAD, 32'h1);
        chk({hce, cada}, 2'h3);
        bus(1'b1, REG_CAD, 32'h0);
        chk(cada, 1'b0);
        bus(1'b1, REG_MODE, {24'($random(seed)), 8'h2});
        chk(pwr, 1'b1);
        bus(1'b1, REG_MODE, 32'h3);
        @(posedge clk_i) fault <= 1'b1;
        wpwr(1'b0);
        @(posedge clk_i) fault <= 1'b0;
        rd_exp(REG_REQ, 32'h11);
        wpwr(1'b1);
        $display("test 2 done");
        bus(1'b1, REG_RST, 32'h1);
        chk(pwr, 1'b0);
        rd_exp(REG_EVENT, 32'h0);
        rd_exp(REG_MODE, 32'h3);
        lat <= 8'h28;
        bus(1'b1, REG_MODE, 32'h2);
        rd_exp(REG_REQ, 32'h0);
        bus(1'b1, REG_REQ, 32'h1);
        bus(1'b1, REG_PWR, 32'h1);
        chk(pwr, 1'b1);
        bus(1'b1, REG_PWR, 32'h10);
        chk(pwr, 1'b0);
        rd_exp(REG_REQ, 32'h0);
        lat <= 8'h4;
        bus(1'b1, REG_REQ, 32'h11);
        repeat (60) @(posedge clk_i);
        chk(pwr, 1'b0);
        $display("test 3 done");
        det_ok <= 1'b0;
        bus(1'b1, REG_CAD, 32'h1);
        bus(1'b1, REG_REQ, 32'h1);
        repeat (3) begin
            gap = 0;
            do begin
                @(posedge clk_i);
                gap++;
            end while (det_st !== 1'b1);
        end
        chk(gap >= BO + 4 && gap <= BO + 14, 1'b1);
        bus(1'b1, REG_MODE, 32'h1);
        bus(1'b1, REG_REQ, 32'h1);
        repeat (40) @(posedge clk_i);
        rd_exp(REG_REQ, 32'h0);
        $display("test 4 done");
        det_ok <= 1'b1;
        bus(1'b1, REG_MODE, 32'h3);
        wpwr(1'b1);
        bus(1'b1, REG_MODE, 32'h0);
        chk(pwr, 1'b0);
        rd_exp(REG_EVENT, 32'h0);
        bus(1'b1, REG_PWR, 32'h1);
        bus(1'b1, REG_REQ, 32'h0);
        repeat (20) @(posedge clk_i);
        chk(pwr, 1'b0);
        rd_exp(REG_REQ, 32'h11);
        bus(1'b1, REG_MODE, 32'h3);
        wpwr(1'b1);
        $display("test 5 done");
        bus(1'b1, REG_RST, 32'h10);
        rd_exp(REG_CAD, 32'h0);
        bus(1'b1, REG_CAD, 32'h1);
        @(posedge clk_i) en_i <= 1'b0;
        repeat (EN_RST_CYC + 10) @(posedge clk_i);
        en_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd_exp(REG_CAD, 32'h0);
        chk({cada, hce}, 2'h2);
        bus(1'b1, REG_MODE, 32'h2);
        @(posedge clk_i) {hot, cool} <= 2'h2;
        repeat (10) @(posedge clk_i);
        hot <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk(pwr, 1'b0);
        cool <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd_exp(REG_MODE, 32'h3);
        $display("test 6 done");
        test_done();
    end
endmodule : testbench
